// ### logic/rrci_defines.vh
// Constants of the recorder remote command interface
// Function
// - Host requests completion notify; device posts a status block per command.
// - Device accepts page-table bit clear or set; host sets page size accordingly.
// - Binary answers start with code 10h and three-byte length, high first.
// - Every answer ends with an asterisk; host keeps reading until it sees one.
// - Protocol query answers one line: protocols tag, supported tags, alphabetical, space separated.
// - Mandatory commands complete within 100 ms; earlier status may show busy.
// - Address query returns tag, mode, own address, mask and gateway.
// - Dynamic mode without assigned address reports all three addresses as zero.
// - Address set supports dynamic, restore defaults, or static; acknowledged by asterisk.
// - Time sync command starts clock sync; lock updates date and time.
// - Sync state query reports locked or none, then an asterisk line.
// - Setup load copies file to buffer; missing file gives error, erases buffer.
// - Setup display outputs buffer then asterisk; empty buffer is no error.
// - Setup store writes buffer under numbered name; foreign media data gives error.
// - Setup upload appends data until a lone END line, then asterisk.
`ifndef RRCI_DEFINES_VH
`define RRCI_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RRCI_ADDR_CMD        8'h00
`define RRCI_ADDR_STATUS     8'h04
`define RRCI_ADDR_STAGE_IP   8'h08
`define RRCI_ADDR_STAGE_MASK 8'h0c
`define RRCI_ADDR_STAGE_GW   8'h10
`define RRCI_ADDR_RESP_DATA  8'h14
`define RRCI_ADDR_RESP_LEFT  8'h18
`define RRCI_ADDR_UPLOAD     8'h1c
`define RRCI_ADDR_ORB        8'h20
`define RRCI_ADDR_STAT_BLK   8'h24

// ----------------------------------------------------------------
// Status register bits, request-word page-table bit and page size
// ----------------------------------------------------------------
`define RRCI_ST_BUSY   0
`define RRCI_ST_DONE   1
`define RRCI_ST_ERR    2
`define RRCI_ST_UPLOAD 3
`define RRCI_ST_DHCP   4
`define RRCI_ST_LOCKED 5
`define RRCI_ST_SYNC   6
`define RRCI_ST_CNT_LO 8
`define RRCI_ST_CNT_HI 12
`define RRCI_ORB_P_BIT 19
`define RRCI_ORB_PS_HI 18
`define RRCI_ORB_PS_LO 16

// ----------------------------------------------------------------
// Command codes and address-set forms
// ----------------------------------------------------------------
`define RRCI_OP_PROTO  4'h1
`define RRCI_OP_NETQ   4'h2
`define RRCI_OP_NETSET 4'h3
`define RRCI_OP_SYNC   4'h4
`define RRCI_OP_SYNCQ  4'h5
`define RRCI_OP_LOAD   4'h6
`define RRCI_OP_DISP   4'h7
`define RRCI_OP_STORE  4'h8
`define RRCI_OP_UPLOAD 4'h9
`define RRCI_FORM_DHCP   2'h0
`define RRCI_FORM_RESET  2'h1
`define RRCI_FORM_STATIC 2'h2

// ----------------------------------------------------------------
// Answer kinds and lengths in words
// ----------------------------------------------------------------
`define RRCI_K_ACK   3'h0
`define RRCI_K_ERR   3'h1
`define RRCI_K_BAD   3'h2
`define RRCI_K_PROTO 3'h3
`define RRCI_K_NET   3'h4
`define RRCI_K_SYNC  3'h5
`define RRCI_K_DISP  3'h6
`define RRCI_LEN_ACK   5'h01
`define RRCI_LEN_ERR   5'h02
`define RRCI_LEN_PROTO 5'h06
`define RRCI_LEN_NET   5'h06
`define RRCI_LEN_SYNC  5'h03

// ----------------------------------------------------------------
// Answer text, four ASCII bytes per word, first byte high
// ----------------------------------------------------------------
`define RRCI_TXT_ACK   32'h2a0a0000
`define RRCI_TXT_ERR   32'h4530310a
`define RRCI_TXT_BAD   32'h4530300a
`define RRCI_TXT_END   32'h454e440a
`define RRCI_TXT_PR0   32'h50524f54
`define RRCI_TXT_PR1   32'h4f434f4c
`define RRCI_TXT_PR2   32'h53204654
`define RRCI_TXT_PR3   32'h50205054
`define RRCI_TXT_PR4   32'h500a0000
`define RRCI_TXT_STAT  32'h53544154
`define RRCI_TXT_DHCP  32'h44484350
`define RRCI_TXT_LOCK0 32'h4c4f434b
`define RRCI_TXT_LOCK1 32'h45440a00
`define RRCI_TXT_NONE0 32'h4e4f4e45
`define RRCI_TXT_NONE1 32'h0a000000
`define RRCI_BIN_CODE  8'h10
`define RRCI_NET_BYTES 24'h000010

// ----------------------------------------------------------------
// Defaults, buffer and timing
// ----------------------------------------------------------------
`define RRCI_DEF_IP    32'h0a000002
`define RRCI_DEF_MASK  32'hff000000
`define RRCI_DEF_GW    32'h0a000001
`define RRCI_BUF_DEPTH 5'h10
`define RRCI_CLK_PERIOD_NS 100
`define RRCI_CMD_TIME_NS   100000000

`endif

// ### logic/rrci_setup_buf.v
// Volatile setup-file buffer, flip-flop storage with two read ports
`include "rrci_defines.vh"
module rrci_setup_buf (
   clk,
   wr_en,
   wr_idx,
   wr_data,
   rd_idx_a,
   rd_data_a,
   rd_idx_b,
   rd_data_b
);
   input  wire        clk;
   input  wire        wr_en;
   input  wire [3:0]  wr_idx;
   input  wire [31:0] wr_data;
   input  wire [3:0]  rd_idx_a;
   output wire [31:0] rd_data_a;
   input  wire [3:0]  rd_idx_b;
   output wire [31:0] rd_data_b;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   wire [31:0] entry [0:15];
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1) begin : g_entry
         reg [31:0] word;
         always @(posedge clk) begin
            if (wr_en && (wr_idx == g[3:0])) begin
               word <= wr_data;
            end
         end
         assign entry[g] = word;
      end
   endgenerate

   assign rd_data_a = entry[rd_idx_a];
   assign rd_data_b = entry[rd_idx_b];
endmodule // rrci_setup_buf

// ### logic/rrci_cmd_engine.v
// Remote command engine: APB registers, command execution, answer stream
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`include "rrci_defines.vh"
module rrci_cmd_engine #(
   parameter CMD_LIMIT_CYCLES = `RRCI_CMD_TIME_NS / `RRCI_CLK_PERIOD_NS
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        ptp_locked,
   input  wire        dhcp_lease_valid,
   input  wire [31:0] dhcp_ip,
   input  wire [31:0] dhcp_mask,
   input  wire [31:0] dhcp_gw,
   input  wire        media_load_wvalid,
   input  wire [31:0] media_load_wdata,
   input  wire        media_load_done,
   input  wire        media_load_bad,
   input  wire        media_store_done,
   input  wire        media_foreign_data,
   input  wire [3:0]  media_rd_addr,
   output reg  [31:0] media_rd_data,
   output reg         media_load_req,
   output reg         media_store_req,
   output reg  [7:0]  media_store_number,
   output reg         net_dhcp_enable,
   output reg  [31:0] net_ip,
   output reg  [31:0] net_mask,
   output reg  [31:0] net_gw,
   output reg         net_reset_defaults,
   output reg         ptp_sync_start,
   output reg         rtc_load_date_time,
   output reg         cmd_complete
);

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   localparam [2:0] ST_IDLE   = 3'b001;
   localparam [2:0] ST_MEDIA  = 3'b010;
   localparam [2:0] ST_UPLOAD = 3'b100;
   localparam [19:0] LIMIT    = CMD_LIMIT_CYCLES[19:0];

   reg  [2:0]  state;
   reg         op_is_load;
   reg  [19:0] cmd_timer;
   reg  [31:0] stage_ip;
   reg  [31:0] stage_mask;
   reg  [31:0] stage_gw;
   reg  [31:0] orb_word;
   reg  [2:0]  resp_kind;
   reg  [4:0]  resp_idx;
   reg  [4:0]  resp_left;
   reg  [4:0]  buf_count;
   reg         done_flag;
   reg         err_flag;
   reg         sync_pending;
   reg         locked_seen;
   reg  [7:0]  stat_blk;
   reg  [31:0] resp_word;
   reg  [31:0] read_mux;
   reg         addr_ok;

   wire [31:0] buf_word_a;
   wire [31:0] buf_word_b;
   wire        busy      = (state == ST_MEDIA);
   wire        apb_setup = psel & ~penable;
   wire        apb_done  = psel & penable & pready;
   wire        wr_fire   = apb_done & pwrite & ~pslverr;
   wire        rd_pop    = apb_done & ~pwrite & ~pslverr & (paddr == `RRCI_ADDR_RESP_DATA);
   wire        cmd_fire  = wr_fire & (paddr == `RRCI_ADDR_CMD) & ~busy & (state != ST_UPLOAD);
   wire [3:0]  cmd_op    = pwdata[3:0];
   wire [1:0]  cmd_form  = pwdata[5:4];
   wire        up_fire   = wr_fire & (paddr == `RRCI_ADDR_UPLOAD) & (state == ST_UPLOAD);
   wire        up_end    = up_fire & (pwdata == `RRCI_TXT_END);
   wire        buf_full  = (buf_count == `RRCI_BUF_DEPTH);
   wire        load_wr   = (state == ST_MEDIA) & op_is_load & media_load_wvalid & ~buf_full;
   wire        up_wr     = up_fire & ~up_end & ~buf_full;
   wire        buf_wr    = load_wr | up_wr;
   wire [31:0] buf_wdata = load_wr ? media_load_wdata : pwdata;
   wire        timed_out = busy & (cmd_timer == LIMIT);
   wire        media_ok  = busy & (op_is_load ? media_load_done : media_store_done);
   wire        media_bad = busy & op_is_load & media_load_bad;
   // Load, upload and a store without foreign data post their completion later; stat_blk is loaded at once
   wire        deferred  = (cmd_op == `RRCI_OP_LOAD) | (cmd_op == `RRCI_OP_UPLOAD) |
                           ((cmd_op == `RRCI_OP_STORE) & ~media_foreign_data);
   wire        new_resp  = (cmd_fire & ~deferred) | up_end | media_ok | media_bad | timed_out;
   wire        clr_done  = wr_fire & (paddr == `RRCI_ADDR_STATUS) & pwdata[`RRCI_ST_DONE];
   wire        clr_err   = wr_fire & (paddr == `RRCI_ADDR_STATUS) & pwdata[`RRCI_ST_ERR];
   wire [31:0] shown_ip   = (net_dhcp_enable & ~dhcp_lease_valid) ? 32'h0 : (net_dhcp_enable ? dhcp_ip : net_ip);
   wire [31:0] shown_mask = (net_dhcp_enable & ~dhcp_lease_valid) ? 32'h0 : (net_dhcp_enable ? dhcp_mask : net_mask);
   wire [31:0] shown_gw   = (net_dhcp_enable & ~dhcp_lease_valid) ? 32'h0 : (net_dhcp_enable ? dhcp_gw : net_gw);

   rrci_setup_buf u_buf (
      .clk       (clk),
      .wr_en     (buf_wr),
      .wr_idx    (buf_count[3:0]),
      .wr_data   (buf_wdata),
      .rd_idx_a  (resp_idx[3:0]),
      .rd_data_a (buf_word_a),
      .rd_idx_b  (media_rd_addr),
      .rd_data_b (buf_word_b)
   );

   // ----------------------------------------------------------------
   // Answer word generator
   // ----------------------------------------------------------------
   always @* begin
      resp_word = `RRCI_TXT_ACK;
      case (resp_kind)
         `RRCI_K_ERR: begin
            if (resp_idx == 5'h0) resp_word = `RRCI_TXT_ERR;
         end
         `RRCI_K_BAD: begin
            if (resp_idx == 5'h0) resp_word = `RRCI_TXT_BAD;
         end
         `RRCI_K_PROTO: begin
            // Supported tags fixed: file transfer and time sync, in order
            case (resp_idx)
               5'h0:    resp_word = `RRCI_TXT_PR0;
               5'h1:    resp_word = `RRCI_TXT_PR1;
               5'h2:    resp_word = `RRCI_TXT_PR2;
               5'h3:    resp_word = `RRCI_TXT_PR3;
               5'h4:    resp_word = `RRCI_TXT_PR4;
               default: resp_word = `RRCI_TXT_ACK;
            endcase
         end
         `RRCI_K_NET: begin
            // Binary answer, raw address words follow the mode tag
            case (resp_idx)
               5'h0:    resp_word = {`RRCI_BIN_CODE, `RRCI_NET_BYTES};
               5'h1:    resp_word = net_dhcp_enable ? `RRCI_TXT_DHCP : `RRCI_TXT_STAT;
               5'h2:    resp_word = shown_ip;
               5'h3:    resp_word = shown_mask;
               5'h4:    resp_word = shown_gw;
               default: resp_word = `RRCI_TXT_ACK;
            endcase
         end
         `RRCI_K_SYNC: begin
            case (resp_idx)
               5'h0:    resp_word = ptp_locked ? `RRCI_TXT_LOCK0 : `RRCI_TXT_NONE0;
               5'h1:    resp_word = ptp_locked ? `RRCI_TXT_LOCK1 : `RRCI_TXT_NONE1;
               default: resp_word = `RRCI_TXT_ACK;
            endcase
         end
         `RRCI_K_DISP: begin
            if (resp_idx < buf_count) resp_word = buf_word_a;
         end
         default: resp_word = `RRCI_TXT_ACK;
      endcase
   end

   // ----------------------------------------------------------------
   // Register read decode
   // ----------------------------------------------------------------
   always @* begin
      read_mux = 32'h0;
      addr_ok  = 1'b1;
      case (paddr)
         `RRCI_ADDR_CMD:        read_mux = 32'h0;
         `RRCI_ADDR_STATUS: begin
            read_mux[`RRCI_ST_BUSY]   = busy;
            read_mux[`RRCI_ST_DONE]   = done_flag;
            read_mux[`RRCI_ST_ERR]    = err_flag;
            read_mux[`RRCI_ST_UPLOAD] = (state == ST_UPLOAD);
            read_mux[`RRCI_ST_DHCP]   = net_dhcp_enable;
            read_mux[`RRCI_ST_LOCKED] = ptp_locked;
            read_mux[`RRCI_ST_SYNC]   = sync_pending;
            read_mux[`RRCI_ST_CNT_HI:`RRCI_ST_CNT_LO] = buf_count;
         end
         `RRCI_ADDR_STAGE_IP:   read_mux = stage_ip;
         `RRCI_ADDR_STAGE_MASK: read_mux = stage_mask;
         `RRCI_ADDR_STAGE_GW:   read_mux = stage_gw;
         `RRCI_ADDR_RESP_DATA:  read_mux = (resp_left != 5'h0) ? resp_word : 32'h0;
         `RRCI_ADDR_RESP_LEFT:  read_mux = {27'h0, resp_left};
         `RRCI_ADDR_UPLOAD:     read_mux = 32'h0;
         `RRCI_ADDR_ORB:        read_mux = orb_word;
         `RRCI_ADDR_STAT_BLK:   read_mux = {24'h0, stat_blk};
         default:               addr_ok  = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // APB slave: one wait-free access phase after every setup
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= apb_setup;
         pslverr <= apb_setup & ~addr_ok;
         if (apb_setup) begin
            prdata <= pwrite ? 32'h0 : read_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // Command execution
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         state              <= ST_IDLE;
         op_is_load         <= 1'b0;
         cmd_timer          <= 20'h0;
         stage_ip           <= `RRCI_DEF_IP;
         stage_mask         <= `RRCI_DEF_MASK;
         stage_gw           <= `RRCI_DEF_GW;
         orb_word           <= 32'h0;
         resp_kind          <= `RRCI_K_ACK;
         resp_idx           <= 5'h0;
         resp_left          <= 5'h0;
         buf_count          <= 5'h0;
         done_flag          <= 1'b0;
         err_flag           <= 1'b0;
         sync_pending       <= 1'b0;
         locked_seen        <= 1'b0;
         stat_blk           <= 8'h0;
         media_rd_data      <= 32'h0;
         media_load_req     <= 1'b0;
         media_store_req    <= 1'b0;
         media_store_number <= 8'h0;
         net_dhcp_enable    <= 1'b0;
         net_ip             <= `RRCI_DEF_IP;
         net_mask           <= `RRCI_DEF_MASK;
         net_gw             <= `RRCI_DEF_GW;
         net_reset_defaults <= 1'b0;
         ptp_sync_start     <= 1'b0;
         rtc_load_date_time <= 1'b0;
         cmd_complete       <= 1'b0;
      end else begin
         media_load_req     <= 1'b0;
         media_store_req    <= 1'b0;
         net_reset_defaults <= 1'b0;
         ptp_sync_start     <= 1'b0;
         rtc_load_date_time <= 1'b0;
         cmd_complete       <= new_resp;
         media_rd_data      <= buf_word_b;
         locked_seen        <= ptp_locked;

         if (wr_fire && paddr == `RRCI_ADDR_STAGE_IP)   stage_ip   <= pwdata;
         if (wr_fire && paddr == `RRCI_ADDR_STAGE_MASK) stage_mask <= pwdata;
         if (wr_fire && paddr == `RRCI_ADDR_STAGE_GW)   stage_gw   <= pwdata;
         // Request word stored as given; page-table setting never refused
         if (wr_fire && paddr == `RRCI_ADDR_ORB)        orb_word   <= pwdata;

         // Lock after a sync request loads both date and time
         if (sync_pending && ptp_locked && !locked_seen) begin
            rtc_load_date_time <= 1'b1;
            sync_pending       <= 1'b0;
         end

         if (buf_wr) buf_count <= buf_count + 5'h1;

         // Reading the answer pops one word
         if (rd_pop && resp_left != 5'h0) begin
            resp_idx  <= resp_idx + 5'h1;
            resp_left <= resp_left - 5'h1;
         end

         // Set wins over a software clear in the same cycle
         if (clr_done) done_flag <= 1'b0;
         if (clr_err)  err_flag  <= 1'b0;
         if (new_resp) begin
            done_flag <= 1'b1;
            resp_idx  <= 5'h0;
            resp_kind <= `RRCI_K_ACK;
            resp_left <= `RRCI_LEN_ACK;
         end

         if (busy) cmd_timer <= cmd_timer + 20'h1;

         case (state)
            ST_IDLE: begin
               if (cmd_fire) begin
                  stat_blk  <= {4'h0, cmd_op};
                  cmd_timer <= 20'h0;
                  case (cmd_op)
                     `RRCI_OP_PROTO: begin
                        resp_kind <= `RRCI_K_PROTO;
                        resp_left <= `RRCI_LEN_PROTO;
                     end
                     `RRCI_OP_NETQ: begin
                        resp_kind <= `RRCI_K_NET;
                        resp_left <= `RRCI_LEN_NET;
                     end
                     `RRCI_OP_NETSET: begin
                        case (cmd_form)
                           `RRCI_FORM_DHCP: net_dhcp_enable <= 1'b1;
                           `RRCI_FORM_RESET: begin
                              net_dhcp_enable    <= 1'b0;
                              net_ip             <= `RRCI_DEF_IP;
                              net_mask           <= `RRCI_DEF_MASK;
                              net_gw             <= `RRCI_DEF_GW;
                              net_reset_defaults <= 1'b1;
                           end
                           `RRCI_FORM_STATIC: begin
                              net_dhcp_enable <= 1'b0;
                              net_ip          <= stage_ip;
                              net_mask        <= stage_mask;
                              net_gw          <= stage_gw;
                           end
                           default: begin
                              resp_kind <= `RRCI_K_BAD;
                              resp_left <= `RRCI_LEN_ERR;
                              err_flag  <= 1'b1;
                           end
                        endcase
                     end
                     `RRCI_OP_SYNC: begin
                        sync_pending   <= 1'b1;
                        ptp_sync_start <= 1'b1;
                     end
                     `RRCI_OP_SYNCQ: begin
                        resp_kind <= `RRCI_K_SYNC;
                        resp_left <= `RRCI_LEN_SYNC;
                     end
                     `RRCI_OP_LOAD: begin
                        // Extra parameter bits are ignored
                        op_is_load     <= 1'b1;
                        buf_count      <= 5'h0;
                        media_load_req <= 1'b1;
                        state          <= ST_MEDIA;
                     end
                     `RRCI_OP_DISP: begin
                        resp_kind <= `RRCI_K_DISP;
                        resp_left <= buf_count + 5'h1;
                     end
                     `RRCI_OP_STORE: begin
                        if (media_foreign_data) begin
                           resp_kind <= `RRCI_K_ERR;
                           resp_left <= `RRCI_LEN_ERR;
                           err_flag  <= 1'b1;
                        end else begin
                           op_is_load         <= 1'b0;
                           media_store_number <= pwdata[15:8];
                           media_store_req    <= 1'b1;
                           state              <= ST_MEDIA;
                        end
                     end
                     `RRCI_OP_UPLOAD: begin
                        // Upload appends; ack is held until the END word
                        state <= ST_UPLOAD;
                     end
                     default: begin
                        resp_kind <= `RRCI_K_BAD;
                        resp_left <= `RRCI_LEN_ERR;
                        err_flag  <= 1'b1;
                     end
                  endcase
                  // Load, upload and a store without foreign data answer later, not now
                  if (cmd_op == `RRCI_OP_LOAD || cmd_op == `RRCI_OP_UPLOAD ||
                      (cmd_op == `RRCI_OP_STORE && !media_foreign_data)) begin
                     resp_left <= 5'h0;
                     done_flag <= done_flag & ~clr_done;
                  end
               end
            end
            ST_MEDIA: begin
               // Media that never answers is cut off at the time limit
               if (media_bad || timed_out) begin
                  if (op_is_load) buf_count <= 5'h0;
                  resp_kind <= `RRCI_K_ERR;
                  resp_left <= `RRCI_LEN_ERR;
                  err_flag  <= 1'b1;
                  state     <= ST_IDLE;
               end else if (media_ok) begin
                  state <= ST_IDLE;
               end
            end
            ST_UPLOAD: begin
               if (up_end) state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

endmodule // rrci_cmd_engine

// ### testbench/rrci_props.sv
// Port checker of the remote command engine
`include "rrci_defines.vh"
module rrci_props (
   input wire logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, ptp_locked, rtc_load_date_time,
   input wire logic        media_load_req, media_store_req, cmd_complete, net_reset_defaults,
   input wire logic [31:0] net_ip
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_setup_ready: assert property (psel && !penable |=> pready) else $error("late ready");
   chk_err_ready: assert property (pslverr |-> pready && penable) else $error("stray error");
   chk_ready_once: assert property (pready |=> !pready) else $error("ready held");
   chk_done_pulse: assert property (cmd_complete |=> !cmd_complete) else $error("long done");
   chk_lock_date: assert property (rtc_load_date_time |-> $past(ptp_locked) && !$past(ptp_locked, 2)) else $error("no lock");
   chk_load_pulse: assert property (media_load_req |=> !media_load_req [*2]) else $error("long load");
   chk_store_cause: assert property (media_store_req |-> $past(psel && penable && pwrite)) else $error("stray store");
   chk_default_ip: assert property (net_reset_defaults |-> ##[0:1] net_ip == `RRCI_DEF_IP) else $error("no ip");
   cover property (media_store_req);
   cover property (rtc_load_date_time);
   cover property (pslverr);
endmodule // rrci_props
bind rrci_cmd_engine rrci_props rrci_props_inst (.*);

// ### testbench/rrci_media_model.sv
// Media side model answering load and store requests
module rrci_media_model (
   input  wire logic        clk, load_req, store_req, fail,
   output logic             wvalid, done, bad, sdone,
   output logic [31:0]      wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {wvalid, done, bad, sdone, wdata} = '0;
   always @(posedge clk) if (load_req) begin
      repeat (2) @(posedge clk);
      {wvalid, wdata} <= {!fail, 32'h53450001};
      @(posedge clk) wdata <= 32'h53450002;
      // Released data is inverted so a stale word never reads as valid
      @(posedge clk) {wvalid, wdata, done, bad} <= {1'b0, ~wdata, !fail, fail};
      @(posedge clk) {done, bad} <= 2'b00;
   end
   always @(posedge clk) if (store_req) begin
      repeat (3) @(posedge clk);
      sdone <= 1'b1;
      @(posedge clk) sdone <= 1'b0;
   end
endmodule // rrci_media_model

// ### testbench/recorder_remote_command_interface_tb.sv
// Self-checking bench of the remote command engine
`include "rrci_defines.vh"
module recorder_remote_command_interface_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] A = `RRCI_TXT_ACK, N = 32'h10000010, U = 32'h41424344;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, ptp_locked = 0, fail = 0, media_foreign_data = 0;
   logic dhcp_lease_valid = 0, err, pready, pslverr, media_load_wvalid, media_load_done, media_load_bad;
   logic media_store_done, media_load_req, media_store_req, net_dhcp_enable, net_reset_defaults, ptp_sync_start;
   logic rtc_load_date_time, cmd_complete;
   logic [7:0] paddr = 0, media_store_number;
   logic [3:0] media_rd_addr = 0;
   logic [31:0] pwdata = 0, dhcp_ip = 0, prdata, media_rd_data, media_load_wdata, net_ip, net_mask, net_gw, r, exp[$];
   int failures = 0, tests_run = 0;
   logic [31:0] orb [4] = '{32'h82900050, 32'h829b0050, 32'h0a200000, 32'h07800000};
   logic [31:0] rows [8][$] = '{'{32'h1, `RRCI_TXT_PR0, `RRCI_TXT_PR1, `RRCI_TXT_PR2, `RRCI_TXT_PR3, `RRCI_TXT_PR4, A},
      '{32'h2, N, `RRCI_TXT_STAT, `RRCI_DEF_IP, `RRCI_DEF_MASK, `RRCI_DEF_GW, A},
      '{32'h5, `RRCI_TXT_NONE0, `RRCI_TXT_NONE1, A}, '{32'h4, A}, '{32'h3, A},
      '{32'h2, N, `RRCI_TXT_DHCP, 32'h0, 32'h0, 32'h0, A},
      '{32'hf, `RRCI_TXT_BAD, A}, '{32'h33, `RRCI_TXT_BAD, A}};
   rrci_cmd_engine #(.CMD_LIMIT_CYCLES(50)) rrci_cmd_engine_inst (.dhcp_mask(dhcp_ip), .dhcp_gw(dhcp_ip), .*);
   rrci_media_model rrci_media_model_inst (.clk, .load_req(media_load_req), .store_req(media_store_req), .fail,
      .wvalid(media_load_wvalid), .done(media_load_done), .bad(media_load_bad), .sdone(media_store_done),
      .wdata(media_load_wdata));
   always #50 clk = ~clk;
   task chk(input logic [31:0] got, want);
      tests_run++;
      if (got !== want) begin failures++; $display("BAD %0t got %h want %h", $time, got, want); end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk) penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      {r, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      @(posedge clk);
   endtask
   // Polls until the answer is posted, then reads it word by word
   task go(input bit s);
      if (s) apb(1, `RRCI_ADDR_CMD, exp[0]);
      r = 0;
      repeat (30) if (r === 0) apb(0, `RRCI_ADDR_RESP_LEFT, 0);
      for (int i = 1; i < exp.size(); i++) begin
         apb(0, `RRCI_ADDR_RESP_DATA, 0);
         chk(r, exp[i]);
      end
      $display("Test of command %h ended", exp[0]);
   endtask
   task end_of_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (rows[k]) begin exp = rows[k]; go(1); end
      fail <= 1'b1;
      exp = '{32'h6, `RRCI_TXT_ERR, A}; go(1);
      fail <= 1'b0;
      exp = '{32'h7, A}; go(1);
      exp = '{32'h6, A}; go(1);
      apb(1, `RRCI_ADDR_CMD, 32'h9);
      apb(1, `RRCI_ADDR_UPLOAD, U);
      apb(1, `RRCI_ADDR_UPLOAD, `RRCI_TXT_END);
      exp = '{32'h9, A}; go(0);
      exp = '{32'h7, 32'h53450001, 32'h53450002, U, A}; go(1);
      media_foreign_data <= 1'b1;
      exp = '{32'h308, `RRCI_TXT_ERR, A}; go(1);
      media_foreign_data <= 1'b0;
      exp = '{32'h308, A}; go(1);
      chk({24'h0, media_store_number}, 32'h3);
      ptp_locked <= 1'b1;
      exp = '{32'h5, `RRCI_TXT_LOCK0, `RRCI_TXT_LOCK1, A}; go(1);
      apb(1, `RRCI_ADDR_STAGE_IP, 32'hc0a80a63);
      exp = '{32'h23, A}; go(1);
      chk(net_ip, 32'hc0a80a63);
      exp = '{32'h13, A}; go(1);
      chk(net_ip, `RRCI_DEF_IP);
      chk(net_mask, `RRCI_DEF_MASK);
      apb(0, 8'h40, 0);
      chk({31'h0, err}, 32'h1);
      dhcp_lease_valid <= 1'b1;
      dhcp_ip <= U;
      exp = '{32'h3, A}; go(1);
      exp = '{32'h2, N, `RRCI_TXT_DHCP, U, U, U, A}; go(1);
      foreach (orb[k]) begin
         apb(1, `RRCI_ADDR_ORB, orb[k]);
         apb(0, `RRCI_ADDR_ORB, 0);
         chk(r, orb[k]);
      end
      chk(media_rd_data, 32'h53450001);
      apb(0, `RRCI_ADDR_STATUS, 0);
      chk(r, 32'h336);
      apb(1, `RRCI_ADDR_STATUS, 32'h6);
      apb(0, `RRCI_ADDR_STATUS, 0);
      chk(r, 32'h330);
      end_of_test();
   end
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin #1000000; failures++; end_of_test(); end
endmodule // recorder_remote_command_interface_tb
